// ### pkg/brmc_regs.vh
// register map and constants of the buck rail mode control block
`ifndef BRMC_REGS_VH
`define BRMC_REGS_VH
`define BRMC_ADDR_CTRL     8'h39
`define BRMC_CTRL_RESET    8'h07
`define BRMC_STATE_LSB     0
`define BRMC_STATE_MSB     2
`define BRMC_EXIT_LSB      3
`define BRMC_EXIT_MSB      5
`define BRMC_VSEL_LSB      6
`define BRMC_VSEL_MSB      7
`define BRMC_ST_OFF        3'h4
`define BRMC_ST_PFM        3'h5
`define BRMC_ST_SKIP       3'h6
`define BRMC_ST_PWM        3'h7
`define BRMC_VSEL_1V5      2'h0
`define BRMC_VSEL_1V6      2'h1
`define BRMC_DISCH_NS      1000
`define BRMC_CLK_NS        8
`define BRMC_DISCH_CYC     ((`BRMC_DISCH_NS + `BRMC_CLK_NS - 1) / `BRMC_CLK_NS)
`endif

// ### core/brmc_sample_reg.v
// holding register for the digitised rail current
`timescale 1ns/1ps
module brmc_sample_reg #(
	parameter W = 10
) (
	input  wire         mclk,
	input  wire         rst_n,
	input  wire         wr_en,
	input  wire [W-1:0] wr_data,
	output reg  [W-1:0] rd_data_ff
);
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_ff <= {W{1'b0}};
		else if (wr_en)
			rd_data_ff <= wr_data;
	end
endmodule // brmc_sample_reg

// ### core/brmc_top.v
// control and status logic of one buck rail
`timescale 1ns/1ps
`include "brmc_regs.vh"

// Contract
// - The rail mode is chosen by register among off, PULSE_FREQUENCY_MODE, skip and PWM.
// - State bits 2:0 decode x4 off, x5 PULSE_FREQUENCY_MODE, x6 skip, x7 PWM; x0-x3 reserved.
// - On the standby exit pin, bits 5:3 copy into the state if x4-x7.
// - Bits 7:6 pick the output level: x0 1.5 V, x1 1.6 V, others reserved.
// - The control register is read/write at 0x39 and resets to 0x07.
// - The output is discharged by the low side switch when the state turns off; a reset turns the rail off without discharge.
// - Output current is converted by the ADC and held for host reads; here it is held on rail_current_ff only, and no register address reads it.
// - Peak over-current limits per cycle and raises the rail fault.
module brmc_top #(
	parameter ADC_W     = 10,
	parameter DISCH_CYC = `BRMC_DISCH_CYC
) (
	input  wire             mclk,
	input  wire             resetn,
	input  wire             reg_wr,
	input  wire             reg_rd,
	input  wire [7:0]       reg_addr,
	input  wire [7:0]       reg_wdata,
	output reg  [7:0]       reg_rdata_ff,
	output reg              reg_ack_ff,
	input  wire             standby_exit_pin,
	input  wire             adc_done,
	input  wire [ADC_W-1:0] adc_result,
	output reg  [ADC_W-1:0] rail_current_ff,
	input  wire             peak_overcurrent,
	output reg              cycle_limit_ff,
	output reg              rail_fault_ff,
	output reg              regulator_fault_interrupt_ff,
	input  wire             fault_clear,
	output reg              rail_enable_ff,
	output reg  [2:0]       mode_ff,
	output reg  [1:0]       vsel_ff,
	output reg              discharge_ff
);
	// ****************************************************
	// reset release
	// ****************************************************
	reg        rst_meta_ff;
	reg        rst_n_ff;
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ****************************************************
	// decoding helpers
	// ****************************************************
	function valid_state;
		input [2:0] code;
		begin
			valid_state = code[2];
		end
	endfunction

	// ****************************************************
	// control register
	// ****************************************************
	reg  [7:0]  ctrl_ff;
	reg  [7:0]  nxt_ctrl;
	reg         exit_prev_ff;
	wire        hit = (reg_addr == `BRMC_ADDR_CTRL);
	wire        exit_rise = standby_exit_pin & ~exit_prev_ff;
	wire [2:0]  exit_code = ctrl_ff[`BRMC_EXIT_MSB:`BRMC_EXIT_LSB];
	wire [2:0]  wr_state = reg_wdata[`BRMC_STATE_MSB:`BRMC_STATE_LSB];
	wire [4:0]  wr_upper = reg_wdata[`BRMC_VSEL_MSB:`BRMC_EXIT_LSB];
	wire [2:0]  cur_state = ctrl_ff[`BRMC_STATE_MSB:`BRMC_STATE_LSB];
	wire [1:0]  cur_vsel = ctrl_ff[`BRMC_VSEL_MSB:`BRMC_VSEL_LSB];

	always @*
	begin
		nxt_ctrl = ctrl_ff;
		if (reg_wr && hit)
		begin
			nxt_ctrl[`BRMC_VSEL_MSB:`BRMC_EXIT_LSB] =
				wr_upper;
			if (valid_state(wr_state))
				nxt_ctrl[`BRMC_STATE_MSB:`BRMC_STATE_LSB] =
					wr_state;
		end
		// pin copy wins over a same-cycle write of the state bits;
		// the host must load the field before it relies on the pin
		if (exit_rise && valid_state(exit_code))
			nxt_ctrl[`BRMC_STATE_MSB:`BRMC_STATE_LSB] =
				exit_code;
	end

	always @(posedge mclk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			ctrl_ff      <= `BRMC_CTRL_RESET;
			exit_prev_ff <= 1'b0;
		end
		else
		begin
			ctrl_ff      <= nxt_ctrl;
			exit_prev_ff <= standby_exit_pin;
		end
	end

	// ****************************************************
	// register read port
	// ****************************************************
	always @(posedge mclk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			reg_rdata_ff <= 8'h00;
			reg_ack_ff   <= 1'b0;
		end
		else
		begin
			// unmapped accesses are acknowledged and read as zero
			reg_ack_ff   <= reg_wr | reg_rd;
			reg_rdata_ff <= (reg_rd && hit) ? ctrl_ff : 8'h00;
		end
	end

	// ****************************************************
	// rail drive and shutdown discharge
	// ****************************************************
	localparam [2:0] ST_RUN   = 3'h1;
	localparam [2:0] ST_DISCH = 3'h2;
	localparam [2:0] ST_IDLE  = 3'h4;
	reg  [2:0]  fsm_ff;
	reg  [2:0]  nxt_fsm;
	// the counter is 16 bits wide, so longer discharge times need a
	// wider one; a zero setting still gives one cycle of discharge
	reg  [15:0] dis_cnt_ff;
	wire [15:0] dis_load = (DISCH_CYC > 0) ?
		DISCH_CYC[15:0] - 16'h0001 : 16'h0000;
	wire        want_on = (cur_state != `BRMC_ST_OFF);
	wire        dis_done = (dis_cnt_ff == 16'h0000);

	always @*
	begin
		case (fsm_ff)
		ST_RUN:   nxt_fsm = want_on ? ST_RUN : ST_DISCH;
		ST_DISCH: nxt_fsm = want_on ? ST_RUN :
			(dis_done ? ST_IDLE : ST_DISCH);
		ST_IDLE:  nxt_fsm = want_on ? ST_RUN : ST_IDLE;
		default:  nxt_fsm = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			fsm_ff         <= ST_IDLE;
			dis_cnt_ff     <= 16'h0000;
			rail_enable_ff <= 1'b0;
			discharge_ff   <= 1'b0;
			mode_ff        <= `BRMC_ST_OFF;
			vsel_ff        <= `BRMC_VSEL_1V5;
		end
		else
		begin
			fsm_ff <= nxt_fsm;
			if (fsm_ff == ST_RUN && nxt_fsm == ST_DISCH)
				dis_cnt_ff <= dis_load;
			else if (!dis_done)
				dis_cnt_ff <= dis_cnt_ff - 16'h0001;
			rail_enable_ff <= (nxt_fsm == ST_RUN);
			discharge_ff   <= (nxt_fsm == ST_DISCH);
			mode_ff        <= cur_state;
			// reserved levels fall back to the default level
			vsel_ff <= (cur_vsel == `BRMC_VSEL_1V6) ?
				`BRMC_VSEL_1V6 : `BRMC_VSEL_1V5;
		end
	end

	// ****************************************************
	// current sample and over-current fault
	// ****************************************************
	wire [ADC_W-1:0] sample;
	brmc_sample_reg #(
		.W(ADC_W)
	) u_sample (
		.mclk      (mclk),
		.rst_n     (rst_n_ff),
		.wr_en     (adc_done),
		.wr_data   (adc_result),
		.rd_data_ff(sample)
	);

	always @(posedge mclk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			rail_current_ff              <= {ADC_W{1'b0}};
			cycle_limit_ff               <= 1'b0;
			rail_fault_ff                <= 1'b0;
			regulator_fault_interrupt_ff <= 1'b0;
		end
		else
		begin
			rail_current_ff <= sample;
			cycle_limit_ff  <= peak_overcurrent & rail_enable_ff;
			// a new event beats a clear in the same cycle
			if (peak_overcurrent && rail_enable_ff)
				rail_fault_ff <= 1'b1;
			else if (fault_clear)
				rail_fault_ff <= 1'b0;
			regulator_fault_interrupt_ff <= rail_fault_ff;
		end
	end
endmodule // brmc_top

// ### tb/brmc_props.sv
// checker of the buck rail control ports
`timescale 1ns/1ps
module brmc_props (
	input wire       mclk,
	input wire       resetn,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_rdata_ff,
	input wire       reg_ack_ff,
	input wire       peak_overcurrent,
	input wire       rail_fault_ff,
	input wire       regulator_fault_interrupt_ff,
	input wire       rail_enable_ff,
	input wire [2:0] mode_ff,
	input wire [1:0] vsel_ff,
	input wire       discharge_ff,
	input wire       cycle_limit_ff,
	input wire       fault_clear
);
// ****
// properties
// ****
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
sequence s_req;
	reg_wr || reg_rd;
endsequence
ack_req_a: assert property (s_req |=> reg_ack_ff)
	else $error("no ack after access");
ack_idle_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack_ff)
	else $error("ack without access");
unmapped_rd_a: assert property (
	reg_rd && reg_addr != 8'h39 |=> reg_rdata_ff == 8'h00)
	else $error("unmapped read not zero");
mode_legal_a: assert property (mode_ff >= 3'h4)
	else $error("undefined mode");
vsel_legal_a: assert property (vsel_ff <= 2'h1)
	else $error("reserved level");
fault_set_a: assert property (
	peak_overcurrent && rail_enable_ff |=> rail_fault_ff)
	else $error("fault not raised");
fault_irq_a: assert property (
	rail_fault_ff |=> regulator_fault_interrupt_ff)
	else $error("interrupt not raised");
disch_off_a: assert property (discharge_ff |-> !rail_enable_ff)
	else $error("discharge while on");
sequence s_trip;
	peak_overcurrent && rail_enable_ff;
endsequence
sequence s_alarm;
	rail_fault_ff ##1 regulator_fault_interrupt_ff;
endsequence
fault_chain_a: assert property (s_trip |=> s_alarm)
	else $error("fault chain broken");
limit_set_a: assert property (s_trip |=> cycle_limit_ff)
	else $error("no cycle limit");
limit_off_a: assert property (!rail_enable_ff |=> !cycle_limit_ff)
	else $error("limit while off");
fault_clr_a: assert property (
	fault_clear && !(peak_overcurrent && rail_enable_ff) |=> !rail_fault_ff)
	else $error("fault not cleared");
irq_drop_a: assert property (
	!rail_fault_ff |=> !regulator_fault_interrupt_ff)
	else $error("interrupt not dropped");
rd_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
	else $error("read data without read");
endmodule // brmc_props
bind brmc_top brmc_props u_props (.*);

// ### tb/brmc_host.sv
// host model issuing control register accesses
`timescale 1ns/1ps
module brmc_host (
	input  wire       mclk,
	input  wire [7:0] reg_rdata_ff,
	output reg        reg_wr = 1'b0,
	output reg        reg_rd = 1'b0,
	output reg  [7:0] reg_addr = 8'h00,
	output reg  [7:0] reg_wdata = 8'h00
);
	// idle bus shows inverted values so stale data never matches
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	end
	endtask
	task rd(input [7:0] a, output [7:0] q);
	begin
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		// read data stands for one cycle after the strobe edge
		q = reg_rdata_ff;
		reg_rd = 1'b0;
		reg_addr = ~a;
	end
	endtask
endmodule // brmc_host

// ### tb/tb_brmc_top.sv
// self-checking bench of the buck rail control block
`timescale 1ns/1ps
module tb_brmc_top;
	reg        mclk = 1'b0, resetn = 1'b0, pin = 1'b0;
	reg        adone = 1'b0, oc = 1'b0, fclr = 1'b0;
	reg  [9:0] ares = 10'h000;
	wire       wr, rd, ack, flt, irq, en, dis, lim;
	wire [7:0] addr, wd, rdat;
	wire [9:0] cur;
	wire [2:0] mode;
	wire [1:0] vsel;
	reg  [7:0] q;
	integer    mismatches = 0, comparisons = 0, i, n;
	brmc_top #(.DISCH_CYC(4)) uut (.mclk(mclk), .resetn(resetn),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
		.reg_rdata_ff(rdat), .reg_ack_ff(ack), .standby_exit_pin(pin),
		.adc_done(adone), .adc_result(ares), .rail_current_ff(cur),
		.peak_overcurrent(oc), .cycle_limit_ff(lim), .rail_fault_ff(flt),
		.regulator_fault_interrupt_ff(irq), .fault_clear(fclr),
		.rail_enable_ff(en), .mode_ff(mode), .vsel_ff(vsel),
		.discharge_ff(dis));
	brmc_host h (.mclk(mclk), .reg_rdata_ff(rdat), .reg_wr(wr),
		.reg_rd(rd), .reg_addr(addr), .reg_wdata(wd));
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	task chk(input string nm, input [15:0] s, input [15:0] e);
	begin
		comparisons = comparisons + 1;
		if (s !== e)
		begin
			mismatches = mismatches + 1;
			$display("FAIL %0s exp %h seen %h", nm, e, s);
		end
	end
	endtask
	task tick(input integer k);
	begin
		repeat (k) @(posedge mclk);
		#1;
	end
	endtask
	task t_modes;
	begin
		h.rd(8'h39, q);
		chk("ctrl", q, 8'h07);
		chk("ack", ack, 1'b1);
		for (i = 4; i < 8; i = i + 1)
		begin
			h.wr(8'h39, i[7:0]);
			chk("ack", ack, 1'b1);
			tick(2);
			chk("mode", mode, i[2:0]);
		end
		h.wr(8'h39, 8'h02);
		h.rd(8'h39, q);
		chk("rsvd", q, 8'h07);
		h.wr(8'h40, 8'h04);
		h.rd(8'h40, q);
		chk("unmap", q, 8'h00);
		chk("ack", ack, 1'b1);
		chk("mode", mode, 3'h7);
		h.wr(8'h39, 8'hc7);
		h.rd(8'h39, q);
		chk("rw", q, 8'hc7);
		chk("vsel", vsel, 2'h0);
		h.wr(8'h39, 8'h47);
		tick(2);
		chk("vsel", vsel, 2'h1);
		$display("t_modes end");
	end
	endtask
	task t_off;
	begin
		h.wr(8'h39, 8'h04);
		n = 0;
		for (i = 0; i < 40; i = i + 1)
		begin
			tick(1);
			if (dis === 1'b1)
				n = n + 1;
		end
		chk("disch", n[15:0], 16'h4);
		chk("en", en, 1'b0);
		$display("t_off end");
	end
	endtask
	task t_exit;
	begin
		h.wr(8'h39, 8'h2f);
		@(negedge mclk);
		pin = 1'b1;
		tick(3);
		chk("exit", mode, 3'h5);
		@(negedge mclk);
		pin = 1'b0;
		h.wr(8'h39, 8'h17);
		@(negedge mclk);
		pin = 1'b1;
		tick(3);
		chk("nocopy", mode, 3'h7);
		@(negedge mclk);
		pin = 1'b0;
		h.wr(8'h39, 8'h37);
		fork
			h.wr(8'h39, 8'h35);
			begin
				@(negedge mclk);
				pin = 1'b1;
			end
		join
		tick(2);
		chk("order", mode, 3'h6);
		@(negedge mclk);
		pin = 1'b0;
		$display("t_exit end");
	end
	endtask
	task t_rst;
	begin
		@(negedge mclk);
		resetn = 1'b0;
		tick(1);
		chk("rstmode", mode, 3'h4);
		chk("rsten", en, 1'b0);
		@(negedge mclk);
		resetn = 1'b1;
		tick(4);
		chk("relmode", mode, 3'h7);
		h.rd(8'h39, q);
		chk("rstval", q, 8'h07);
		$display("t_rst end");
	end
	endtask
	task t_flt;
	begin
		tick(4);
		chk("on", en, 1'b1);
		@(negedge mclk);
		ares = 10'h2a5;
		adone = 1'b1;
		oc = 1'b1;
		@(negedge mclk);
		chk("limit", lim, 1'b1);
		ares = 10'h15a;
		adone = 1'b0;
		oc = 1'b0;
		tick(2);
		chk("cur", cur, 10'h2a5);
		chk("limit", lim, 1'b0);
		chk("flt", flt, 1'b1);
		chk("irq", irq, 1'b1);
		@(negedge mclk);
		fclr = 1'b1;
		oc = 1'b1;
		@(negedge mclk);
		oc = 1'b0;
		chk("setwin", flt, 1'b1);
		@(negedge mclk);
		fclr = 1'b0;
		chk("clr", flt, 1'b0);
		tick(1);
		chk("irqclr", irq, 1'b0);
		h.wr(8'h39, 8'h04);
		tick(8);
		@(negedge mclk);
		oc = 1'b1;
		@(negedge mclk);
		oc = 1'b0;
		tick(1);
		chk("offflt", flt, 1'b0);
		chk("offlim", lim, 1'b0);
		$display("t_flt end");
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		tick(4);
		t_modes;
		t_off;
		t_exit;
		t_rst;
		t_flt;
		end_of_test;
	end
endmodule // tb_brmc_top
